// ==== hdl/gfs_pin_func_sel.sv ====
// Pin function select for pins P1.7 and P2.0 to P2.3, APB register access
`timescale 1ns/1ns

module gfs_pin_func_sel #(
	parameter int ADDR_W = 18
) (
	input wire logic CLOCK_I, // System clock, 20 MHz
	input wire logic RESET_N_I, // Asynchronous reset, active low
	// APB slave
	input wire logic PSEL_I, // Slave select
	input wire logic PENABLE_I, // Access phase
	input wire logic PWRITE_I, // Write when high
	input wire logic [ADDR_W-1:0] PADDR_I, // Byte address
	input wire logic [31:0] PWDATA_I, // Write data
	input wire logic [3:0] PSTRB_I, // Byte strobes
	output logic [31:0] PRDATA_O, // Read data
	output logic PREADY_O, // Always ready
	output logic PSLVERR_O, // Unmapped address
	// Pads, index 0 is P1.7, 1 to 4 are P2.0 to P2.3
	input wire logic [gfs_pkg::NUM_PINS-1:0] PAD_I, // Pad level
	output logic [gfs_pkg::NUM_PINS-1:0] PAD_O, // Pad drive value
	output logic [gfs_pkg::NUM_PINS-1:0] PAD_OE_O, // Pad drive enable
	// Plain io
	input wire logic [gfs_pkg::NUM_PINS-1:0] GPIO_OUT_I, // Port output data
	input wire logic [gfs_pkg::NUM_PINS-1:0] GPIO_OE_I, // Port output enable
	output logic [gfs_pkg::NUM_PINS-1:0] GPIO_IN_O, // Port input data
	// Pwm channels
	input wire logic PWM_CH10_I, // Pwm ch10 output
	input wire logic PWM_CH2_I, // Pwm ch2 output
	input wire logic PWM_CH3_I, // Pwm ch3 output
	input wire logic PWM_CH4_I, // Pwm ch4 output
	input wire logic PWM_CH5_I, // Pwm ch5 output
	// Serial ports
	input wire logic LIN_TX_I, // Lin serial port transmit
	input wire logic BASIC_TX_I, // Basic serial port transmit
	output logic LIN_RX_O, // Lin serial port receive
	output logic BASIC_RX_O, // Basic serial port receive
	// I2c units
	input wire logic I2C_MASTER_UNIT_SDA_I, // Master data drive value
	input wire logic I2C_MASTER_UNIT_SDA_OE_I, // Master data drive enable
	output logic I2C_MASTER_UNIT_SDA_O, // Master data line level
	input wire logic I2C_MASTER_UNIT_SCL_I, // Master clock drive value
	input wire logic I2C_MASTER_UNIT_SCL_OE_I, // Master clock drive enable
	output logic I2C_MASTER_UNIT_SCL_O, // Master clock line level
	input wire logic I2CSB_SDA_I, // Slave b data drive value
	input wire logic I2CSB_SDA_OE_I, // Slave b data drive enable
	output logic I2CSB_SDA_O, // Slave b data line level
	input wire logic I2CSB_SCL_I, // Slave b clock drive value
	input wire logic I2CSB_SCL_OE_I, // Slave b clock drive enable
	output logic I2CSB_SCL_O, // Slave b clock line level
	// Buzzer and spi
	input wire logic BUZZER_I, // Buzzer waveform
	input wire logic SPI_MISO_I, // Miso drive value
	input wire logic SPI_MISO_OE_I, // Miso drive enable
	output logic SPI_MISO_O, // Miso line level
	input wire logic SPI_SCK_I, // Sck drive value
	input wire logic SPI_SCK_OE_I, // Sck drive enable, master role
	output logic SPI_SCK_O, // Sck line level
	input wire logic SPI_MOSI_I, // Mosi drive value
	input wire logic SPI_MOSI_OE_I, // Mosi drive enable
	output logic SPI_MOSI_O, // Mosi line level
	output logic SPI_SSN_O, // Slave select, active low
	// Timers and pin interrupts
	output logic TIMER_ONE_IN_O, // Timer 1 external input
	output logic TIMER_TWO_IN_O, // Timer 2 external input
	output logic TIMER_TWO_TRIG_O, // Timer 2 capture/reload trigger
	output logic TIMER_ZERO_IN_O, // Timer 0 external input
	output logic PIN_IRQ_A_SEL_O, // P1.7 selected for pin irq a
	output logic PIN_IRQ_B_SEL_O, // P1.7 selected for pin irq b
	output logic PIN_IRQ_A_COND_O, // P1.7 level toward pin irq a
	output logic PIN_IRQ_B_COND_O // P1.7 level toward pin irq b
);
	import gfs_pkg::*;

	// ==========================================================
	// Registers and APB decode
	gfs_cfg_t cfg_q [NUM_PINS];
	logic [NUM_PINS-1:0] hit;
	logic any_hit;
	logic wr_en;
	logic [31:0] rd_d;

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_dec
			assign hit[gp] = (PADDR_I[1:0] == 2'h0)
				&& (PADDR_I[ADDR_W-1:2] == REG_IDX[gp][ADDR_W-3:0]);
		end
	endgenerate

	assign any_hit = |hit;
	assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0];
	assign PREADY_O = 1'b1;

	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_reg
			always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					cfg_q[gp] <= CFG_RST;
				end else if (wr_en && hit[gp]) begin
					cfg_q[gp] <= PWDATA_I[7:0] & WMASK[gp];
				end
			end
		end
	endgenerate

	always_comb begin
		rd_d = 32'h0000_0000;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (hit[i]) begin
				rd_d = {24'h00_0000, cfg_q[i]};
			end
		end
	end

	// Read data and error are prepared in the setup cycle so both are flops
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else if (PSEL_I && !PENABLE_I) begin
			PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_d;
			PSLVERR_O <= !any_hit;
		end else if (!PSEL_I) begin
			PSLVERR_O <= 1'b0;
		end
	end

	// ==========================================================
	// Pad input synchroniser
	logic [NUM_PINS-1:0] pad_s1_q;
	logic [NUM_PINS-1:0] pad_s2_q;

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pad_s1_q <= '0;
			pad_s2_q <= '0;
		end else begin
			pad_s1_q <= PAD_I;
			pad_s2_q <= pad_s1_q;
		end
	end

	// ==========================================================
	// Output function tables, one bit per config bit
	gfs_cfg_t fn_out [NUM_PINS];
	gfs_cfg_t fn_oe [NUM_PINS];

	assign fn_out[PIN_P17] = {PWM_CH10_I, LIN_TX_I, BASIC_TX_I, 4'h0, GPIO_OUT_I[PIN_P17]};
	assign fn_oe[PIN_P17] = {3'h7, 4'h0, GPIO_OE_I[PIN_P17]};
	assign fn_out[PIN_P20] = {PWM_CH2_I, I2C_MASTER_UNIT_SDA_I, I2CSB_SDA_I, BUZZER_I, SPI_MISO_I,
		2'h0, GPIO_OUT_I[PIN_P20]};
	// I2c enables come from the unit; open-drain setup of the pad is up to software
	assign fn_oe[PIN_P20] = {1'b1, I2C_MASTER_UNIT_SDA_OE_I, I2CSB_SDA_OE_I, 1'b1, SPI_MISO_OE_I,
		2'h0, GPIO_OE_I[PIN_P20]};
	assign fn_out[PIN_P21] = {PWM_CH3_I, I2C_MASTER_UNIT_SCL_I, I2CSB_SCL_I, BUZZER_I, SPI_SCK_I,
		2'h0, GPIO_OUT_I[PIN_P21]};
	assign fn_oe[PIN_P21] = {1'b1, I2C_MASTER_UNIT_SCL_OE_I, I2CSB_SCL_OE_I, 1'b1, SPI_SCK_OE_I,
		2'h0, GPIO_OE_I[PIN_P21]};
	assign fn_out[PIN_P22] = {PWM_CH4_I, 3'h0, SPI_MOSI_I, 2'h0, GPIO_OUT_I[PIN_P22]};
	assign fn_oe[PIN_P22] = {1'b1, 3'h0, SPI_MOSI_OE_I, 2'h0, GPIO_OE_I[PIN_P22]};
	assign fn_out[PIN_P23] = {PWM_CH5_I, LIN_TX_I, BASIC_TX_I, 4'h0, GPIO_OUT_I[PIN_P23]};
	assign fn_oe[PIN_P23] = {3'h7, 4'h0, GPIO_OE_I[PIN_P23]};

	// ==========================================================
	// Pad drive: highest set output bit wins, lower ones are ignored
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_pad
			logic out_d;
			logic oe_d;
			always_comb begin
				out_d = 1'b0;
				oe_d = 1'b0;
				for (int b = 0; b < 8; b++) begin
					if (cfg_q[gp][b] && OUT_CAP[gp][b]) begin
						out_d = fn_out[gp][b];
						oe_d = fn_oe[gp][b];
					end
				end
			end
			always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					PAD_O[gp] <= 1'b0;
					PAD_OE_O[gp] <= 1'b0;
				end else begin
					PAD_O[gp] <= out_d;
					PAD_OE_O[gp] <= oe_d;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Peripheral inputs; an unrouted input sits at its idle level
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			GPIO_IN_O <= '0;
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				GPIO_IN_O[i] <= pad_s2_q[i] & cfg_q[i][BIT_PLAIN_IO];
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			LIN_RX_O <= 1'b1;
			BASIC_RX_O <= 1'b1;
		end else begin
			LIN_RX_O <= cfg_q[PIN_P22][BIT_HI_SER] ? pad_s2_q[PIN_P22] : 1'b1;
			BASIC_RX_O <= cfg_q[PIN_P22][BIT_LO_SER] ? pad_s2_q[PIN_P22] : 1'b1;
		end
	end

	// Unrouted i2c lines read high, as a pulled-up bus would
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			I2C_MASTER_UNIT_SDA_O <= 1'b1;
			I2C_MASTER_UNIT_SCL_O <= 1'b1;
			I2CSB_SDA_O <= 1'b1;
			I2CSB_SCL_O <= 1'b1;
		end else begin
			I2C_MASTER_UNIT_SDA_O <= cfg_q[PIN_P20][BIT_HI_SER] ? pad_s2_q[PIN_P20] : 1'b1;
			I2C_MASTER_UNIT_SCL_O <= cfg_q[PIN_P21][BIT_HI_SER] ? pad_s2_q[PIN_P21] : 1'b1;
			I2CSB_SDA_O <= cfg_q[PIN_P20][BIT_LO_SER] ? pad_s2_q[PIN_P20] : 1'b1;
			I2CSB_SCL_O <= cfg_q[PIN_P21][BIT_LO_SER] ? pad_s2_q[PIN_P21] : 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			SPI_MISO_O <= 1'b0;
			SPI_SCK_O <= 1'b0;
			SPI_MOSI_O <= 1'b0;
			SPI_SSN_O <= 1'b1;
		end else begin
			SPI_MISO_O <= cfg_q[PIN_P20][BIT_SPI] & pad_s2_q[PIN_P20];
			SPI_SCK_O <= cfg_q[PIN_P21][BIT_SPI] & pad_s2_q[PIN_P21];
			SPI_MOSI_O <= cfg_q[PIN_P22][BIT_SPI] & pad_s2_q[PIN_P22];
			SPI_SSN_O <= cfg_q[PIN_P23][BIT_SPI] ? pad_s2_q[PIN_P23] : 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			TIMER_ONE_IN_O <= 1'b0;
			TIMER_TWO_IN_O <= 1'b0;
			TIMER_TWO_TRIG_O <= 1'b0;
			TIMER_ZERO_IN_O <= 1'b0;
		end else begin
			TIMER_ONE_IN_O <= cfg_q[PIN_P20][BIT_AUX_IN] & pad_s2_q[PIN_P20];
			TIMER_TWO_IN_O <= cfg_q[PIN_P21][BIT_AUX_IN] & pad_s2_q[PIN_P21];
			TIMER_TWO_TRIG_O <= cfg_q[PIN_P22][BIT_AUX_IN] & pad_s2_q[PIN_P22];
			TIMER_ZERO_IN_O <= cfg_q[PIN_P23][BIT_AUX_IN] & pad_s2_q[PIN_P23];
		end
	end

	// Both sources are independent, so one pin may feed either or both
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PIN_IRQ_A_COND_O <= 1'b0;
			PIN_IRQ_B_COND_O <= 1'b0;
		end else begin
			PIN_IRQ_A_COND_O <= cfg_q[PIN_P17][BIT_AUX_IN] & pad_s2_q[PIN_P17];
			PIN_IRQ_B_COND_O <= cfg_q[PIN_P17][BIT_IRQ_B] & pad_s2_q[PIN_P17];
		end
	end

	assign PIN_IRQ_A_SEL_O = cfg_q[PIN_P17][BIT_AUX_IN];
	assign PIN_IRQ_B_SEL_O = cfg_q[PIN_P17][BIT_IRQ_B];

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);

	sequence s_apb_write(int pin);
		PSEL_I && !PENABLE_I && PWRITE_I && PSTRB_I[0] && hit[pin]
			##1 PSEL_I && PENABLE_I && $stable(PWDATA_I);
	endsequence

	AST_PWM10_DRIVE: assert property ($past(cfg_q[PIN_P17][BIT_PWM])
		|-> PAD_O[PIN_P17] == $past(PWM_CH10_I) && PAD_OE_O[PIN_P17])
		else $error("P1.7 not driven from pwm ch10");
	AST_TX_ROUTE: assert property ($past(cfg_q[PIN_P23][7:5] == 3'h1)
		|-> PAD_O[PIN_P23] == $past(BASIC_TX_I) && PAD_OE_O[PIN_P23])
		else $error("P2.3 not driven from basic tx");
	AST_LIN_TX: assert property ($past(cfg_q[PIN_P17][7:6] == 2'h1)
		|-> PAD_O[PIN_P17] == $past(LIN_TX_I))
		else $error("P1.7 not driven from lin tx");
	AST_IRQ_B: assert property ($past(cfg_q[PIN_P17][BIT_IRQ_B])
		|-> PIN_IRQ_B_COND_O == $past(PAD_I[PIN_P17], 3))
		else $error("Pin irq b condition does not follow P1.7");
	AST_IRQ_A: assert property (!$past(cfg_q[PIN_P17][BIT_AUX_IN])
		|-> !PIN_IRQ_A_COND_O)
		else $error("Pin irq a condition set while unselected");
	AST_IRQ_BOTH: assert property ($past(cfg_q[PIN_P17][2:1] == 2'h3)
		|-> PIN_IRQ_A_COND_O == PIN_IRQ_B_COND_O)
		else $error("Pin feeding both irq sources disagrees");
	AST_PLAIN_IO: assert property ($past(cfg_q[PIN_P22] == 8'h01)
		|-> PAD_OE_O[PIN_P22] == $past(GPIO_OE_I[PIN_P22])
		&& GPIO_IN_O[PIN_P22] == $past(PAD_I[PIN_P22], 3))
		else $error("Plain io path wrong on P2.2");
	AST_CFG_WRITE: assert property (s_apb_write(PIN_P21)
		|=> cfg_q[PIN_P21] == ($past(PWDATA_I[7:0]) & WMASK[PIN_P21]))
		else $error("Config write not stored");
	AST_I2C_MASTER_UNIT_SCL: assert property ($past(cfg_q[PIN_P21][7:6] == 2'h1)
		|-> PAD_OE_O[PIN_P21] == $past(I2C_MASTER_UNIT_SCL_OE_I)
		&& I2C_MASTER_UNIT_SCL_O == $past(PAD_I[PIN_P21], 3))
		else $error("I2c master clock not routed");
	AST_I2CSB_SCL: assert property ($past(cfg_q[PIN_P21][7:5] == 3'h1)
		|-> PAD_O[PIN_P21] == $past(I2CSB_SCL_I))
		else $error("I2c slave b clock not routed");
	AST_BUZZER: assert property ($past(cfg_q[PIN_P21][7:4] == 4'h1)
		|-> PAD_O[PIN_P21] == $past(BUZZER_I) && PAD_OE_O[PIN_P21])
		else $error("Buzzer not driven on P2.1");
	AST_SCK: assert property ($past(cfg_q[PIN_P21][7:3] == 5'h01)
		|-> PAD_OE_O[PIN_P21] == $past(SPI_SCK_OE_I)
		&& SPI_SCK_O == $past(PAD_I[PIN_P21], 3))
		else $error("Spi clock not routed both ways");
	AST_TIMER_TWO: assert property (!$past(cfg_q[PIN_P21][BIT_AUX_IN])
		|-> !TIMER_TWO_IN_O)
		else $error("Timer 2 input active while unrouted");
	AST_PWM3: assert property ($past(cfg_q[PIN_P21][BIT_PWM])
		|-> PAD_O[PIN_P21] == $past(PWM_CH3_I) && PAD_OE_O[PIN_P21])
		else $error("P2.1 not driven from pwm ch3");
	AST_PWM4: assert property ($past(cfg_q[PIN_P22][BIT_PWM])
		|-> PAD_O[PIN_P22] == $past(PWM_CH4_I) && PAD_OE_O[PIN_P22])
		else $error("P2.2 not driven from pwm ch4");
	AST_RX: assert property ($past(cfg_q[PIN_P22][BIT_LO_SER])
		|-> BASIC_RX_O == $past(PAD_I[PIN_P22], 3))
		else $error("Basic rx does not follow P2.2");
	AST_MOSI: assert property ($past(cfg_q[PIN_P22][7:3] == 5'h01)
		|-> PAD_O[PIN_P22] == $past(SPI_MOSI_I)
		&& SPI_MOSI_O == $past(PAD_I[PIN_P22], 3))
		else $error("Spi mosi not routed");
	AST_TRIG: assert property ($past(cfg_q[PIN_P22][BIT_AUX_IN])
		|-> TIMER_TWO_TRIG_O == $past(PAD_I[PIN_P22], 3))
		else $error("Timer 2 trigger does not follow P2.2");
	AST_PWM5: assert property ($past(cfg_q[PIN_P23][BIT_PWM])
		|-> PAD_O[PIN_P23] == $past(PWM_CH5_I) && PAD_OE_O[PIN_P23])
		else $error("P2.3 not driven from pwm ch5");
	AST_SSN: assert property (!$past(cfg_q[PIN_P23][BIT_SPI]) |-> SPI_SSN_O)
		else $error("Spi select asserted while unrouted");
	AST_TIMER_ZERO: assert property ($past(cfg_q[PIN_P23][BIT_AUX_IN])
		|-> TIMER_ZERO_IN_O == $past(PAD_I[PIN_P23], 3))
		else $error("Timer 0 input does not follow P2.3");

endmodule : gfs_pin_func_sel

// ==== hdl/gfs_pkg.sv ====
// Shared constants for the pin function select block
package gfs_pkg;

	// ==========================================================
	// Pins handled by this block
	localparam int NUM_PINS = 5;
	localparam int PIN_P17 = 0;
	localparam int PIN_P20 = 1;
	localparam int PIN_P21 = 2;
	localparam int PIN_P22 = 3;
	localparam int PIN_P23 = 4;

	typedef logic [7:0] gfs_cfg_t;

	// ==========================================================
	// Register indices; the byte address is four times the index
	localparam logic [15:0] IDX_P17_CFG = 16'hA05F;
	localparam logic [15:0] IDX_P20_CFG = 16'hA070;
	localparam logic [15:0] IDX_P21_CFG = 16'hA071;
	localparam logic [15:0] IDX_P22_CFG = 16'hA072;
	localparam logic [15:0] IDX_P23_CFG = 16'hA073;
	localparam logic [15:0] REG_IDX [NUM_PINS] = '{IDX_P17_CFG, IDX_P20_CFG,
		IDX_P21_CFG, IDX_P22_CFG, IDX_P23_CFG};
	localparam gfs_cfg_t CFG_RST = 8'h00;

	// Implemented bits per register; the rest read as zero
	localparam gfs_cfg_t WMASK [NUM_PINS] = '{8'hE7, 8'hFB, 8'hFB, 8'hEB, 8'hEB};
	// Bits whose function can drive the pad
	localparam gfs_cfg_t OUT_CAP [NUM_PINS] = '{8'hE1, 8'hF9, 8'hF9, 8'h89, 8'hE1};

	// ==========================================================
	// Field positions
	localparam int BIT_PWM = 7;
	localparam int BIT_HI_SER = 6;  // lin port or i2c master
	localparam int BIT_LO_SER = 5;  // basic port or i2c slave b
	localparam int BIT_BUZZER = 4;
	localparam int BIT_SPI = 3;
	localparam int BIT_IRQ_B = 2;
	localparam int BIT_AUX_IN = 1;  // pin irq a or timer input
	localparam int BIT_PLAIN_IO = 0;

	// Synchroniser plus output register: pad to peripheral input latency
	localparam int IN_LATENCY = 3;

endpackage : gfs_pkg

// ==== test/tb_gpio_pin_function_select.sv ====
// Self-checking testbench for the pin function select block
`timescale 1ns/1ns
module tb_gpio_pin_function_select;
	import gfs_pkg::*;
	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [17:0] paddr = 18'h0_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [4:0] pad_i = 5'h00, pad_o, pad_oe, gpio_out = 5'h00, gpio_oe = 5'h00, gpio_in;
	logic [15:0] src = 16'h0000;
	logic en = 1'b1;
	logic lin_rx, basic_rx, msda, mscl, ssda, sscl, miso, sck, mosi, ssn;
	logic t1, t2, t2x, t0, sel_a, sel_b, cond_a, cond_b;
	int fail_count = 0;
	int comparisons = 0;
	// Address is four times the register index
	logic [17:0] byte_addr [5] = '{18'h2_817C, 18'h2_81C0, 18'h2_81C4, 18'h2_81C8, 18'h2_81CC};
	// Rows: pin, written value, winning source (-1 means pad released)
	int row_pin [29] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3,
		4, 4, 4, 4, 4, 4, 3};
	logic [7:0] row_cfg [29] = '{8'h80, 8'h40, 8'h20, 8'h01, 8'hC0, 8'h06, 8'h80, 8'h40, 8'h20,
		8'h10, 8'h08, 8'h02, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h80, 8'h08, 8'h40,
		8'h02, 8'h80, 8'h40, 8'h20, 8'h08, 8'h21, 8'h01, 8'h01};
	int row_src [29] = '{0, 5, 6, 15, 0, -1, 1, 7, 9, 11, 12, -1, 2, 8, 10, 11, 13, -1, 3, 14,
		-1, -1, 4, 5, 6, -1, 6, 15, 15};
	logic [7:0] impl_bits [5] = '{8'hE7, 8'hFB, 8'hFB, 8'hEB, 8'hEB};
	logic [31:0] rd;
	logic err;

	gfs_pin_func_sel #(.ADDR_W(18)) dut_u (
		.CLOCK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.PAD_I(pad_i), .PAD_O(pad_o), .PAD_OE_O(pad_oe),
		.GPIO_OUT_I(gpio_out), .GPIO_OE_I(gpio_oe), .GPIO_IN_O(gpio_in),
		.PWM_CH10_I(src[0]), .PWM_CH2_I(src[1]), .PWM_CH3_I(src[2]), .PWM_CH4_I(src[3]),
		.PWM_CH5_I(src[4]), .LIN_TX_I(src[5]), .BASIC_TX_I(src[6]),
		.LIN_RX_O(lin_rx), .BASIC_RX_O(basic_rx),
		.I2C_MASTER_UNIT_SDA_I(src[7]), .I2C_MASTER_UNIT_SDA_OE_I(en), .I2C_MASTER_UNIT_SDA_O(msda),
		.I2C_MASTER_UNIT_SCL_I(src[8]), .I2C_MASTER_UNIT_SCL_OE_I(en), .I2C_MASTER_UNIT_SCL_O(mscl),
		.I2CSB_SDA_I(src[9]), .I2CSB_SDA_OE_I(en), .I2CSB_SDA_O(ssda),
		.I2CSB_SCL_I(src[10]), .I2CSB_SCL_OE_I(en), .I2CSB_SCL_O(sscl),
		.BUZZER_I(src[11]), .SPI_MISO_I(src[12]), .SPI_MISO_OE_I(en), .SPI_MISO_O(miso),
		.SPI_SCK_I(src[13]), .SPI_SCK_OE_I(en), .SPI_SCK_O(sck),
		.SPI_MOSI_I(src[14]), .SPI_MOSI_OE_I(en), .SPI_MOSI_O(mosi), .SPI_SSN_O(ssn),
		.TIMER_ONE_IN_O(t1), .TIMER_TWO_IN_O(t2), .TIMER_TWO_TRIG_O(t2x),
		.TIMER_ZERO_IN_O(t0), .PIN_IRQ_A_SEL_O(sel_a), .PIN_IRQ_B_SEL_O(sel_b),
		.PIN_IRQ_A_COND_O(cond_a), .PIN_IRQ_B_COND_O(cond_b)
	);

	// ==========================================================
	// Clock and helpers
	initial begin
		forever #25 clk = ~clk;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; the answer is taken at the edge where pready is seen high
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the watchdog ends a wait that never sees pready
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Pattern k gives source i the value of bit k of i, so four patterns identify it
	task automatic check_pad(input int pin, input int s);
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 16; i++) begin
				src[i] <= logic'((i >> k) & 1);
			end
			gpio_out <= {5{logic'((15 >> k) & 1)}};
			@(posedge clk);
			@(posedge clk);
			if (s < 0) begin
				check(pad_oe[pin], 1'b0);
			end else begin
				check({pad_oe[pin], pad_o[pin]}, {1'b1, logic'((s >> k) & 1)});
			end
		end
	endtask : check_pad

	task automatic settle_pad(input logic [4:0] v);
		pad_i <= v;
		repeat (5) @(posedge clk);
	endtask : settle_pad

	task automatic tally_and_finish;
		$display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Watchdog: the full sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end

	// ==========================================================
	// Main sequence
	initial begin
		gpio_oe <= 5'h1F;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		check({pad_oe, lin_rx, basic_rx, ssn, msda}, {5'h00, 4'hF});
		for (int p = 0; p < 5; p++) begin
			apb(1'b0, byte_addr[p], 32'h0000_0000, rd, err);
			check({err, rd}, 33'h0_0000_0000);
		end
		$display("reset values done");
		// Ordinary routings
		for (int r = 0; r < 29; r++) begin
			apb(1'b1, byte_addr[row_pin[r]], {24'h00_0000, row_cfg[r]}, rd, err);
			apb(1'b0, byte_addr[row_pin[r]], 32'h0000_0000, rd, err);
			check(rd, {24'h00_0000, row_cfg[r]});
			check_pad(row_pin[r], row_src[r]);
		end
		$display("routing rows done");
		// All bits set: reserved bits read zero, the pwm bit wins every pad
		for (int p = 0; p < 5; p++) begin
			apb(1'b1, byte_addr[p], 32'hFFFF_FFFF, rd, err);
			apb(1'b0, byte_addr[p], 32'h0000_0000, rd, err);
			check(rd, {24'h00_0000, impl_bits[p]});
			check_pad(p, p);
		end
		$display("priority done");
		// Unmapped word just past P1.7 and at zero
		apb(1'b1, 18'h2_8180, 32'h0000_00FF, rd, err);
		check(err, 1'b1);
		apb(1'b0, 18'h2_8180, 32'h0000_0000, rd, err);
		check({err, rd}, 33'h1_0000_0000);
		apb(1'b0, 18'h0_0000, 32'h0000_0000, rd, err);
		check({err, rd}, 33'h1_0000_0000);
		$display("unmapped done");
		// Input routings
		apb(1'b1, byte_addr[0], 32'h0000_0006, rd, err);
		apb(1'b1, byte_addr[1], 32'h0000_0003, rd, err);
		apb(1'b1, byte_addr[2], 32'h0000_0003, rd, err);
		apb(1'b1, byte_addr[3], 32'h0000_0043, rd, err);
		apb(1'b1, byte_addr[4], 32'h0000_000B, rd, err);
		settle_pad(5'h1F);
		check({sel_a, sel_b, cond_a, cond_b}, 4'hF);
		check({lin_rx, basic_rx, ssn, t1, t2, t2x, t0, gpio_in}, {7'h7F, 5'h1E});
		settle_pad(5'h00);
		check({sel_a, sel_b, cond_a, cond_b}, 4'hC);
		check({lin_rx, basic_rx, ssn, t1, t2, t2x, t0, gpio_in}, {7'h20, 5'h00});
		apb(1'b1, byte_addr[3], 32'h0000_0020, rd, err);
		apb(1'b1, byte_addr[0], 32'h0000_0002, rd, err);
		settle_pad(5'h00);
		check({lin_rx, basic_rx, sel_a, sel_b, cond_b}, 5'h14);
		$display("input routing done");
		// Spi clock in slave role: pad released, line level follows the pad
		en <= 1'b0;
		apb(1'b1, byte_addr[2], 32'h0000_0008, rd, err);
		settle_pad(5'h04);
		check({pad_oe[2], sck}, 2'b01);
		settle_pad(5'h00);
		check({pad_oe[2], sck}, 2'b00);
		apb(1'b1, byte_addr[2], 32'h0000_0040, rd, err);
		settle_pad(5'h00);
		check({pad_oe[2], mscl, sscl}, 3'b001);
		apb(1'b1, byte_addr[2], 32'h0000_0020, rd, err);
		settle_pad(5'h00);
		check({pad_oe[2], mscl, sscl}, 3'b010);
		$display("slave role done");
		// Open-drain data line: the unit releases, the pad floats and the line reads the pad
		apb(1'b1, byte_addr[1], 32'h0000_0040, rd, err);
		settle_pad(5'h02);
		check({pad_oe[1], msda, ssda, miso}, 4'b0110);
		settle_pad(5'h00);
		check({pad_oe[1], msda}, 2'b00);
		apb(1'b1, byte_addr[1], 32'h0000_0028, rd, err);
		settle_pad(5'h00);
		check({msda, ssda, miso}, 3'b100);
		$display("open-drain release done");
		// Reset in mid-run clears every routing
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		check({pad_oe, ssn, sel_a, sel_b}, {5'h00, 3'h4});
		rst_n <= 1'b1;
		apb(1'b0, byte_addr[4], 32'h0000_0000, rd, err);
		check({err, rd}, 33'h0_0000_0000);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule : tb_gpio_pin_function_select
